// [logic/drwd_decoder.sv]
`timescale 1ns/1ps
// Contract
// - Words steer the drive only while control source is the option port.
// - One to six words per transfer; words past the configured size are dropped.
// - Word 0 is always the control word.
// - Words not scheduled stay readable and writable via the reference file.
// - Sequencing bits sampled every 20 ms; edges compare successive samples.
// - Run mode starts only on a rising start bit.
// - Jog mode: start bit is a level, jog while 1, stop at 0.
// - Bit 1 is stop permit: 0 stops, 1 allows running.
// - Rising bit 2 clears latched faults, error log untouched.
// - Bit 3 selects run (0) or jog (1).
// - Bit 4 selects forward (0) or reverse (1).
// - Bit 5 enables the outer control loop.
// - Bit 7 picks torque (0) or speed (1), only in vector control.
// - Rising bit 8 clears the error log, faults untouched.
// - Word 1 full scale 4095, meaning set by regulation mode.
// - Word 2 trim scaled like speed, ignored in torque regulation.
// - Word 3 inertia compensation used only with use flag bit 1.
// - Word 4 clamps speed PI from above when use flag bit 2 set.
// - Word 5 clamps speed PI from below, -4095 full scale.
// - Speed values consumed by speed loop every 6 ms.
// - Torque loop runs every 500 us, reusing each reference.
module drwd_decoder #(
  parameter int SEQ_CYCLES = drwd_pkg::SEQ_CYC,
  parameter int SPD_CYCLES = drwd_pkg::SPD_CYC,
  parameter int TRQ_CYCLES = drwd_pkg::TRQ_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              sched_valid,
  input  wire logic [2:0]        sched_index,
  input  wire logic [15:0]       sched_data,
  input  wire logic [7:0]        addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [15:0]            rdata,
  output drwd_pkg::drwd_cmd_t    cmd,
  output drwd_pkg::drwd_mode_t   ref_mode,
  output logic [15:0]            speed_ref,
  output logic [15:0]            trim_ref,
  output logic [15:0]            inertia_ref,
  output logic [15:0]            pi_high,
  output logic [15:0]            pi_low,
  output logic [15:0]            torque_ref,
  output logic                   speed_tick,
  output logic                   torque_tick
);

  function automatic logic [23:0] cnt_nxt(input logic [23:0] c, input int lim);
    cnt_nxt = (c >= 24'(lim - 1)) ? 24'h000000 : c + 24'h000001;
  endfunction : cnt_nxt

  function automatic logic [15:0] sat_hi(input logic [15:0] v);
    sat_hi = ($signed(v) > $signed(drwd_pkg::LIM_MAX)) ? drwd_pkg::LIM_MAX : v;
  endfunction : sat_hi

  function automatic logic [15:0] sat_lo(input logic [15:0] v);
    sat_lo = ($signed(v) < $signed(drwd_pkg::LIM_MIN)) ? drwd_pkg::LIM_MIN : v;
  endfunction : sat_lo

  logic [15:0]          ref_mem [0:drwd_pkg::NWORDS-1];
  logic                 src_r;
  logic                 vec_r;
  logic [2:0]           size_r;
  logic [2:0]           use_r;
  logic [15:0]          rdata_r;
  logic [23:0]          seq_cnt_r;
  logic [23:0]          spd_cnt_r;
  logic [23:0]          trq_cnt_r;
  drwd_pkg::drwd_cw_t   samp_r;
  drwd_pkg::drwd_cmd_t  cmd_r;
  drwd_pkg::drwd_mode_t mode_r;
  logic [15:0]          spd_r;
  logic [15:0]          trim_r;
  logic [15:0]          iner_r;
  logic [15:0]          hi_r;
  logic [15:0]          lo_r;
  logic [15:0]          trq_r;
  logic                 spd_tick_r;
  logic                 trq_tick_r;

  // Decoding
  drwd_pkg::drwd_cw_t cw;
  wire logic          seq_tick;
  wire logic          spd_due;
  wire logic          trq_due;
  wire logic          start_rise;
  wire logic          flt_rise;
  wire logic          elog_rise;
  wire logic          sched_ok;
  wire logic          ref_hit;
  wire logic [2:0]    ref_idx;
  wire logic          bus_ok;
  wire logic [2:0]    wsize;
  wire logic [15:0]   stat_word;
  wire logic [15:0]   cfg_word;
  wire logic          spd_sel_eff;
  logic [15:0]        rd_mux;

  assign cw          = drwd_pkg::drwd_cw_t'(ref_mem[0]);
  assign seq_tick    = (seq_cnt_r == 24'(SEQ_CYCLES - 1));
  assign spd_due     = (spd_cnt_r == 24'(SPD_CYCLES - 1));
  assign trq_due     = (trq_cnt_r == 24'(TRQ_CYCLES - 1));
  // Edges against the previous 20 ms sample, not the live word
  assign start_rise  = cw.start & ~samp_r.start;
  assign flt_rise    = cw.flt_rst & ~samp_r.flt_rst;
  assign elog_rise   = cw.elog_clr & ~samp_r.elog_clr;
  assign sched_ok    = sched_valid && (sched_index < size_r);
  assign ref_hit     = (addr >= drwd_pkg::A_REF0) && (addr <= drwd_pkg::A_REF5)
                       && (addr[1:0] == 2'b00);
  assign ref_idx     = 3'((addr - drwd_pkg::A_REF0) >> 2);
  // Scheduled words belong to the network; the rest to the file
  assign bus_ok      = wr && ref_hit && (ref_idx >= size_r);
  assign wsize       = wdata[drwd_pkg::CFG_SZ +: 3];
  assign spd_sel_eff = vec_r ? cw.spd_sel : 1'b1;
  assign cfg_word    = {11'h000, size_r, vec_r, src_r};
  assign stat_word   = {9'h000, cmd_r};

  always_comb begin
    rd_mux = 16'h0000;
    if (addr == drwd_pkg::A_CFG) begin
      rd_mux = cfg_word;
    end else if (addr == drwd_pkg::A_USE) begin
      rd_mux = {13'h0000, use_r};
    end else if (addr == drwd_pkg::A_STAT) begin
      rd_mux = stat_word;
    end else if (ref_hit) begin
      rd_mux = ref_mem[ref_idx];
    end
  end

  // Register bus
  always_ff @(posedge clk) begin
    if (rst) begin
      src_r  <= 1'b0;
      vec_r  <= 1'b0;
      size_r <= drwd_pkg::SIZE_RST;
      use_r  <= 3'h0;
    end else if (wr && addr == drwd_pkg::A_CFG) begin
      src_r <= wdata[drwd_pkg::CFG_SRC];
      vec_r <= wdata[drwd_pkg::CFG_VEC];
      // Out of range sizes are pinned to 1..6
      if (wsize == 3'h0) begin
        size_r <= 3'h1;
      end else if (wsize > 3'h6) begin
        size_r <= 3'h6;
      end else begin
        size_r <= wsize;
      end
    end else if (wr && addr == drwd_pkg::A_USE) begin
      use_r <= wdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rd ? rd_mux : 16'h0000;
    end
  end

  // Reference file
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < drwd_pkg::NWORDS; i++) begin
        ref_mem[i] <= 16'h0000;
      end
    end else begin
      if (sched_ok) begin
        ref_mem[sched_index] <= sched_data;
      end
      if (bus_ok) begin
        ref_mem[ref_idx] <= wdata;
      end
    end
  end

  // Loop rate dividers
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_cnt_r <= 24'h000000;
      spd_cnt_r <= 24'h000000;
      trq_cnt_r <= 24'h000000;
    end else begin
      seq_cnt_r <= cnt_nxt(seq_cnt_r, SEQ_CYCLES);
      spd_cnt_r <= cnt_nxt(spd_cnt_r, SPD_CYCLES);
      trq_cnt_r <= cnt_nxt(trq_cnt_r, TRQ_CYCLES);
    end
  end

  // Sequencing, evaluated only at the 20 ms sample
  always_ff @(posedge clk) begin
    if (rst) begin
      samp_r <= '0;
      cmd_r  <= '0;
    end else if (!src_r) begin
      samp_r <= '0;
      cmd_r  <= '0;
    end else if (seq_tick) begin
      samp_r            <= cw;
      cmd_r.jog         <= cw.jog;
      cmd_r.rev         <= cw.rev;
      cmd_r.outer_control_loop         <= cw.outer_control_loop;
      cmd_r.speed_reg   <= spd_sel_eff;
      cmd_r.fault_reset <= flt_rise;
      cmd_r.elog_clear  <= elog_rise;
      if (!cw.stop_ok) begin
        cmd_r.run <= 1'b0;
      end else if (cw.jog) begin
        cmd_r.run <= cw.start;
      end else if (start_rise) begin
        cmd_r.run <= 1'b1;
      end else if (samp_r.jog) begin
        cmd_r.run <= 1'b0;
      end
    end else begin
      cmd_r.fault_reset <= 1'b0;
      cmd_r.elog_clear  <= 1'b0;
    end
  end

  // Reference consumption at the loop rates
  always_ff @(posedge clk) begin
    if (rst || !src_r) begin
      mode_r     <= drwd_pkg::MODE_VHZ;
      spd_r      <= 16'h0000;
      trim_r     <= 16'h0000;
      iner_r     <= 16'h0000;
      hi_r       <= drwd_pkg::LIM_MAX;
      lo_r       <= drwd_pkg::LIM_MIN;
      trq_r      <= 16'h0000;
      spd_tick_r <= 1'b0;
      trq_tick_r <= 1'b0;
    end else begin
      mode_r     <= !vec_r ? drwd_pkg::MODE_VHZ :
                    cmd_r.speed_reg ? drwd_pkg::MODE_VEC : drwd_pkg::MODE_TORQUE;
      spd_tick_r <= spd_due && cmd_r.speed_reg;
      trq_tick_r <= trq_due && !cmd_r.speed_reg;
      if (!cmd_r.speed_reg) begin
        trim_r <= 16'h0000;
      end
      if (spd_due && cmd_r.speed_reg) begin
        spd_r  <= ref_mem[1];
        trim_r <= ref_mem[2];
        iner_r <= use_r[1] ? ref_mem[3] : 16'h0000;
        hi_r   <= use_r[2] ? sat_hi(ref_mem[4]) : drwd_pkg::LIM_MAX;
        lo_r   <= use_r[2] ? sat_lo(ref_mem[5]) : drwd_pkg::LIM_MIN;
      end
      // Same value may be taken several times between network updates
      if (trq_due && !cmd_r.speed_reg) begin
        trq_r <= ref_mem[1];
      end
    end
  end

  assign rdata       = rdata_r;
  assign cmd         = cmd_r;
  assign ref_mode    = mode_r;
  assign speed_ref   = spd_r;
  assign trim_ref    = trim_r;
  assign inertia_ref = iner_r;
  assign pi_high     = hi_r;
  assign pi_low      = lo_r;
  assign torque_ref  = trq_r;
  assign speed_tick  = spd_tick_r;
  assign torque_tick = trq_tick_r;

  chk_src_gate: assert property (@(posedge clk) disable iff (rst)
    !src_r |=> !cmd_r.run && !cmd_r.jog && !cmd_r.fault_reset)
    else $error("commands active without option port source");

  chk_run_edge: assert property (@(posedge clk) disable iff (rst)
    src_r && seq_tick && cw.stop_ok && !cw.jog && !samp_r.jog && !start_rise
      && !cmd_r.run |=> !cmd_r.run)
    else $error("run started without rising start bit");

  chk_run_start: assert property (@(posedge clk) disable iff (rst)
    src_r && seq_tick && cw.stop_ok && !cw.jog && start_rise |=> cmd_r.run)
    else $error("rising start bit did not start drive");

  chk_jog_level: assert property (@(posedge clk) disable iff (rst)
    src_r && seq_tick && cw.jog && cw.stop_ok |=> cmd_r.run == $past(cw.start))
    else $error("jog does not follow start level");

  chk_stop_permit: assert property (@(posedge clk) disable iff (rst)
    src_r && seq_tick && !cw.stop_ok |=> !cmd_r.run)
    else $error("drive running with stop permit low");

  chk_fault_pulse: assert property (@(posedge clk) disable iff (rst)
    cmd_r.fault_reset |=> !cmd_r.fault_reset ##1 !cmd_r.fault_reset)
    else $error("fault reset longer than one cycle");

  chk_elog_edge: assert property (@(posedge clk) disable iff (rst)
    src_r && seq_tick && elog_rise |=> cmd_r.elog_clear && !$past(cmd_r.elog_clear))
    else $error("error log clear missing after rising bit");

  chk_trim_torque: assert property (@(posedge clk) disable iff (rst)
    !cmd_r.speed_reg && src_r |=> trim_r == 16'h0000)
    else $error("trim used in torque regulation");

  chk_hi_clamp: assert property (@(posedge clk) disable iff (rst)
    $signed(hi_r) <= $signed(drwd_pkg::LIM_MAX) && $signed(lo_r) >= $signed(drwd_pkg::LIM_MIN))
    else $error("PI limits outside full scale");

  chk_trq_take: assert property (@(posedge clk) disable iff (rst)
    src_r && trq_due && !cmd_r.speed_reg |=> trq_r == $past(ref_mem[1]) ##1 trq_tick_r == 1'b0)
    else $error("torque reference not taken at loop tick");

  chk_mode_sel: assert property (@(posedge clk) disable iff (rst)
    src_r && seq_tick |=> cmd_r.jog == $past(cw.jog))
    else $error("run or jog mode not taken from control word");

  chk_dir_sel: assert property (@(posedge clk) disable iff (rst)
    src_r && seq_tick |=> cmd_r.rev == $past(cw.rev))
    else $error("direction not taken from control word");

  chk_ocl_sel: assert property (@(posedge clk) disable iff (rst)
    src_r && seq_tick |=> cmd_r.outer_control_loop == $past(cw.outer_control_loop))
    else $error("outer loop enable not taken from control word");

  chk_reg_sel: assert property (@(posedge clk) disable iff (rst)
    src_r && seq_tick |=> cmd_r.speed_reg == (!$past(vec_r) || $past(cw.spd_sel)))
    else $error("regulation select wrong for control type");

  chk_seq_hold: assert property (@(posedge clk) disable iff (rst)
    src_r && !seq_tick |=> $stable(cmd_r.run) && $stable(cmd_r.jog) && $stable(samp_r))
    else $error("sequencing changed between samples");

  chk_jog_exit: assert property (@(posedge clk) disable iff (rst)
    src_r && seq_tick && cw.stop_ok && !cw.jog && samp_r.jog && !start_rise |=> !cmd_r.run)
    else $error("drive kept running after leaving jog");

  chk_flt_only: assert property (@(posedge clk) disable iff (rst)
    src_r && seq_tick && flt_rise && !elog_rise |=> cmd_r.fault_reset && !cmd_r.elog_clear)
    else $error("fault reset missing or touched error log");

  chk_elog_only: assert property (@(posedge clk) disable iff (rst)
    src_r && seq_tick && elog_rise && !flt_rise |=> cmd_r.elog_clear && !cmd_r.fault_reset)
    else $error("error log clear missing or touched faults");

  chk_size_range: assert property (@(posedge clk) disable iff (rst)
    size_r != 3'h0 && size_r <= 3'h6)
    else $error("configured word count outside one to six");

  chk_file_guard: assert property (@(posedge clk) disable iff (rst)
    wr && ref_hit && ref_idx < size_r && !(sched_ok && sched_index == ref_idx)
      |=> ref_mem[$past(ref_idx)] == $past(ref_mem[ref_idx]))
    else $error("scheduled word overwritten from reference file");

  chk_file_write: assert property (@(posedge clk) disable iff (rst)
    bus_ok |=> ref_mem[$past(ref_idx)] == $past(wdata))
    else $error("reference file write lost");

  chk_file_read: assert property (@(posedge clk) disable iff (rst)
    rd && ref_hit |=> rdata_r == $past(ref_mem[ref_idx]))
    else $error("reference file read returned wrong word");

  chk_iner_gate: assert property (@(posedge clk) disable iff (rst)
    src_r && spd_due && cmd_r.speed_reg && !use_r[1] |=> iner_r == 16'h0000)
    else $error("inertia compensation used with flag clear");

  chk_hi_take: assert property (@(posedge clk) disable iff (rst)
    src_r && spd_due && cmd_r.speed_reg && use_r[2]
      && $signed(ref_mem[4]) <= $signed(drwd_pkg::LIM_MAX) |=> hi_r == $past(ref_mem[4]))
    else $error("PI high limit not taken from word 4");

  chk_lo_sat: assert property (@(posedge clk) disable iff (rst)
    src_r && spd_due && cmd_r.speed_reg && use_r[2]
      && $signed(ref_mem[5]) < $signed(drwd_pkg::LIM_MIN) |=> lo_r == drwd_pkg::LIM_MIN)
    else $error("PI low limit not pinned to full scale");

  chk_spd_take: assert property (@(posedge clk) disable iff (rst)
    src_r && spd_due && cmd_r.speed_reg |=> spd_r == $past(ref_mem[1]) && spd_tick_r)
    else $error("speed reference not taken at loop tick");

endmodule : drwd_decoder

// [logic/drwd_pkg.sv]
package drwd_pkg;
  localparam int CLK_HZ  = 40_000_000;
  localparam int SEQ_MS  = 20;
  localparam int SPD_MS  = 6;
  localparam int TRQ_US  = 500;
  localparam int SEQ_CYC = CLK_HZ / 1000 * SEQ_MS;
  localparam int SPD_CYC = CLK_HZ / 1000 * SPD_MS;
  localparam int TRQ_CYC = CLK_HZ / 1000 * TRQ_US / 1000;

  localparam int NWORDS = 6;
  localparam logic [7:0] A_CFG    = 8'h00;
  localparam logic [7:0] A_USE    = 8'h04;
  localparam logic [7:0] A_STAT   = 8'h08;
  localparam logic [7:0] A_REF0   = 8'h10;
  localparam logic [7:0] A_REF5   = 8'h24;
  localparam int CFG_SRC = 0;
  localparam int CFG_VEC = 1;
  localparam int CFG_SZ  = 2;
  localparam logic [2:0] SIZE_RST = 3'h6;
  localparam logic [15:0] LIM_MAX = 16'h0FFF;
  localparam logic [15:0] LIM_MIN = 16'hF001;

  typedef struct packed {
    logic [6:0] rsv_hi;
    logic       elog_clr;
    logic       spd_sel;
    logic       rsv6;
    logic       outer_control_loop;
    logic       rev;
    logic       jog;
    logic       flt_rst;
    logic       stop_ok;
    logic       start;
  } drwd_cw_t;

  typedef struct packed {
    logic run;
    logic jog;
    logic rev;
    logic outer_control_loop;
    logic speed_reg;
    logic fault_reset;
    logic elog_clear;
  } drwd_cmd_t;

  typedef enum logic [1:0] {
    MODE_VHZ    = 2'b00,
    MODE_VEC    = 2'b01,
    MODE_TORQUE = 2'b10
  } drwd_mode_t;
endpackage : drwd_pkg

// [tb/drwd_ctrl_model.sv]
`timescale 1ns/1ps
// Controller side: sends one scheduled block, word 0 first, optional idle gap
module drwd_ctrl_model (
  input  wire logic        clk,
  input  wire logic        send,
  input  wire logic [2:0]  size,
  input  wire logic [3:0]  gap,
  input  wire logic [95:0] words,
  output logic             sched_valid,
  output logic [2:0]       sched_index,
  output logic [15:0]      sched_data,
  output logic             busy
);
  initial begin
    sched_valid = 1'b0;
    sched_index = 3'h0;
    sched_data  = 16'h0000;
    busy        = 1'b0;
    forever begin
      @(posedge clk);
      if (send) begin
        busy <= 1'b1;
        for (int i = 0; i < int'(size); i++) begin
          sched_valid <= 1'b1;
          sched_index <= i[2:0];
          sched_data  <= words[i*16 +: 16];
          @(posedge clk);
          // Back to back words keep valid up; a released bus never shows the last word
          if (gap != 4'h0 || i == int'(size) - 1) begin
            sched_valid <= 1'b0;
            sched_data  <= ~words[i*16 +: 16];
            repeat (gap) @(posedge clk);
          end
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : drwd_ctrl_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  localparam int SEQ = 20;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 send = 1'b0;
  logic [2:0]           size = 3'h6;
  logic [3:0]           gap = 4'h0;
  logic [95:0]          words = '0;
  logic [7:0]           addr = 8'h00;
  logic [15:0]          wdata = 16'h0000;
  logic                 wr = 1'b0;
  logic                 rd = 1'b0;
  logic                 sched_valid, busy, speed_tick, torque_tick;
  logic [2:0]           sched_index;
  logic [15:0]          sched_data, rdata, speed_ref, trim_ref, inertia_ref;
  logic [15:0]          pi_high, pi_low, torque_ref;
  drwd_pkg::drwd_cmd_t  cmd;
  drwd_pkg::drwd_mode_t ref_mode;
  int                   num_errors = 0;
  int                   n_checks = 0;
  int                   n_flt = 0;
  int                   n_elog = 0;
  int                   cyc = 0;

  drwd_ctrl_model ctl (.clk(clk), .send(send), .size(size), .gap(gap), .words(words),
    .sched_valid(sched_valid), .sched_index(sched_index), .sched_data(sched_data),
    .busy(busy));
  drwd_decoder #(.SEQ_CYCLES(SEQ), .SPD_CYCLES(12), .TRQ_CYCLES(5)) uut (.clk(clk),
    .rst(rst), .sched_valid(sched_valid), .sched_index(sched_index),
    .sched_data(sched_data), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cmd(cmd), .ref_mode(ref_mode), .speed_ref(speed_ref), .trim_ref(trim_ref),
    .inertia_ref(inertia_ref), .pi_high(pi_high), .pi_low(pi_low),
    .torque_ref(torque_ref), .speed_tick(speed_tick), .torque_tick(torque_tick));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // Pulses are counted so a doubled or missing clear shows up
  always @(posedge clk) begin
    cyc++;
    if (cmd.fault_reset === 1'b1) n_flt++;
    if (cmd.elog_clear === 1'b1) n_elog++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk

  // Two full sampling periods so both edge samples have seen the new word
  task automatic send_blk(input logic [95:0] w, input logic [2:0] n);
    @(posedge clk);
    words <= w;
    size  <= n;
    send  <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    #1;
    for (int i = 0; i < 80 && busy; i++) @(posedge clk);
    repeat (2 * SEQ + 2) @(posedge clk);
    #1;
  endtask : send_blk

  task automatic wait_tick(input bit trq);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (i < 40 && (trq ? torque_tick : speed_tick) !== 1'b1);
    chk({15'h0, trq ? torque_tick : speed_tick}, 16'h0001);
  endtask : wait_tick

  task automatic src_off;
    send_blk(96'h0400_0003, 3'h6);
    chk({9'h0, cmd}, 16'h0000);
    chk(speed_ref, 16'h0000);
  endtask : src_off

  task automatic start_stop;
    wr_reg(drwd_pkg::A_CFG, 16'h001B);
    send_blk(96'hFEF3, 3'h6);
    chk({9'h0, cmd}, 16'h005C);
    chk({14'h0, ref_mode}, {14'h0, drwd_pkg::MODE_VEC});
    rd_chk(drwd_pkg::A_STAT, 16'h005C);
    send_blk(96'hFEF1, 3'h6);
    chk({9'h0, cmd}, 16'h001C);
    send_blk(96'hFEF3, 3'h6);
    chk({9'h0, cmd}, 16'h001C);
    send_blk(96'hFEF2, 3'h6);
    send_blk(96'hFEF3, 3'h6);
    chk({9'h0, cmd}, 16'h005C);
  endtask : start_stop

  task automatic jog_mode;
    gap = 4'h2;
    send_blk(96'h000B, 3'h6);
    chk({9'h0, cmd}, 16'h0060);
    chk({14'h0, ref_mode}, {14'h0, drwd_pkg::MODE_TORQUE});
    send_blk(96'h000A, 3'h6);
    chk({9'h0, cmd}, 16'h0020);
    gap = 4'h0;
  endtask : jog_mode

  task automatic flt_elog;
    send_blk(96'h0006, 3'h6);
    chk(16'(n_flt), 16'h0001);
    chk(16'(n_elog), 16'h0000);
    send_blk(96'h0102, 3'h6);
    chk(16'(n_flt), 16'h0001);
    chk(16'(n_elog), 16'h0001);
  endtask : flt_elog

  task automatic refs;
    wr_reg(drwd_pkg::A_USE, 16'h0006);
    rd_chk(drwd_pkg::A_USE, 16'h0006);
    send_blk(96'hF000_0800_0123_0100_0FFF_0082, 3'h6);
    wait_tick(1'b0);
    chk(speed_ref, 16'h0FFF);
    chk(trim_ref, 16'h0100);
    chk(inertia_ref, 16'h0123);
    chk(pi_high, 16'h0800);
    chk(pi_low, 16'hF001);
    wr_reg(drwd_pkg::A_USE, 16'h0000);
    wait_tick(1'b0);
    chk(inertia_ref, 16'h0000);
    chk(pi_high, 16'h0FFF);
    send_blk(96'hF000_0800_0123_0100_0FFF_0002, 3'h6);
    wait_tick(1'b1);
    chk(torque_ref, 16'h0FFF);
    chk(trim_ref, 16'h0000);
  endtask : refs

  // Controller sends more words than configured: extras must be dropped
  task automatic size_file;
    wr_reg(drwd_pkg::A_CFG, 16'h000B);
    wr_reg(8'h20, 16'h0300);
    rd_chk(8'h20, 16'h0300);
    wr_reg(8'h14, 16'h0700);
    rd_chk(8'h14, 16'h0FFF);
    send_blk(96'h0000_0555_0000_0000_0FFF_0002, 3'h6);
    rd_chk(8'h20, 16'h0300);
    rd_chk(8'h40, 16'h0000);
  endtask : size_file

  // Without vector control the torque select bit is ignored; size field pinned to 1..6
  task automatic vhz_cfg;
    wr_reg(drwd_pkg::A_CFG, 16'h001D);
    rd_chk(drwd_pkg::A_CFG, 16'h0019);
    send_blk(96'h0002, 3'h6);
    chk({9'h0, cmd}, 16'h0004);
    chk({14'h0, ref_mode}, {14'h0, drwd_pkg::MODE_VHZ});
    wr_reg(drwd_pkg::A_CFG, 16'h0001);
    rd_chk(drwd_pkg::A_CFG, 16'h0005);
  endtask : vhz_cfg

  task automatic rst_mid;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({9'h0, cmd}, 16'h0000);
    chk(pi_low, 16'hF001);
    rd_chk(drwd_pkg::A_CFG, 16'h0018);
  endtask : rst_mid

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({9'h0, cmd}, 16'h0000);
    chk(pi_high, 16'h0FFF);
    chk(pi_low, 16'hF001);
    src_off();
    start_stop();
    jog_mode();
    flt_elog();
    refs();
    size_file();
    vhz_cfg();
    rst_mid();
    test_done();
  end
endmodule : tb_top
